// >>> src/charger_irq_pkg.sv
// Purpose: shared constants and types for the charger interrupt and two-wire read block
// Assumes: register map and bit positions as listed below
// Notes:   status bit positions and the limit field positions are fixed here
package charger_irq_pkg;
  // bus address and sub-addresses
  localparam logic [6:0] SLAVE_ADDR   = 7'h09;
  localparam logic [7:0] SUB_CTL0     = 8'h00;
  localparam logic [7:0] SUB_CTL1     = 8'h01;
  localparam logic [7:0] SUB_CTL2     = 8'h02;
  localparam logic [7:0] SUB_STAT3    = 8'h03;
  localparam logic [7:0] SUB_STAT4    = 8'h04;
  localparam logic [7:0] SUB_STAT5    = 8'h05;
  localparam logic [7:0] SUB_MASK     = 8'h06;
  localparam logic [7:0] SUB_CTL7     = 8'h07;
  // reset values and read fill values
  localparam logic [7:0] CMD_RESET    = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;
  // limit field codes, low five bits of ctl0 (primary) and ctl1 (adapter)
  localparam logic [4:0] LIMIT_100MA  = 5'h00;
  localparam logic [4:0] LIMIT_CUSTOM = 5'h1f;
  // trigger groups over {stat3, stat4}; order matches mask bits 7..2
  // stat3: [7:5] charger state, [4] bad cell, [3] on_the_go_active_flag,
  //        [2] id_line_detect_flag, [1] on_the_go_fault_flag, [0] thermistor_hot_flag
  // stat4: [7] primary_input_good, [6] adapter_input_good, [5] external_power_good,
  //        [4] overvoltage_flag, [3] input_limited_flag, [2] input_undervoltage_flag
  localparam logic [15:0] TRIG_CHARGER = 16'he000;
  localparam logic [15:0] TRIG_FAULT   = 16'h1310;
  localparam logic [15:0] TRIG_POWER   = 16'h00e0;
  localparam logic [15:0] TRIG_OTG     = 16'h0c00;
  localparam logic [15:0] TRIG_ILIM    = 16'h0008;
  localparam logic [15:0] TRIG_UVCL    = 16'h0004;

  typedef struct packed {
    logic [7:0] stat3;
    logic [7:0] stat4;
    logic [7:0] stat5;
  } status_t;

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] mask;
    logic [7:0] ctl7;
  } command_t;

  typedef struct packed {
    logic    scl;
    logic    sda;
    logic    power;
    logic    custom;
    status_t stat;
  } pins_t;

  typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_FILL} bus_state_t;

  typedef struct packed {
    pins_t      s1;
    pins_t      s2;
    pins_t      s3;
    pins_t      flt;
    pins_t      prev;
    bus_state_t bus;
    logic [3:0] cnt;
    logic [1:0] bidx;
    logic       rw;
    logic [7:0] sh;
    logic [7:0] ptr;
    command_t   pend;
    command_t   act;
    logic       irq_pend;
    status_t    frozen;
    logic       irq_n;
    logic       sda_oe;
    logic       sda_out;
  } design_t;
endpackage

// >>> src/charger_irq_and_smbus_read.sv
// Purpose: two-wire slave with status freeze, maskable interrupt and limit defaults
// Assumes: scl, sda, power and status arrive asynchronously and are filtered here
// Notes:   command writes stay pending until stop; status reads use a snapshot
`timescale 1ns/1ps
`default_nettype none

// Operation
// - receive-byte read returns register at pointer, never changes pointer
// - pointer changes only by write-byte, read-byte or send-byte, else holds
// - start plus address 0x09 with read bit is acknowledged
// - after read address ack the device drives data bits, master clocks
// - exactly one data byte is sent, master ack or nack ignored
// - enabled event holds interrupt pin low as a level
// - triggering interrupt latches all three status bytes until cleared
// - command registers never freeze; reads show current or pending data
// - six independently maskable trigger groups
// - mask at 0x06, bits 7..2 enable the six groups, low bits unused
// - all groups masked at reset; a one enables a group
// - any data write to 0x06 clears pending request at its ack
// - clearing releases the pin and unfreezes status bytes
// - each group triggers on its own listed status flags
// - single-resistor setup: power applied selects 100mA limit code
// - custom setup: power applied selects custom limit code
// - both limit fields read back the mode in force
// - without pending request, status read is sampled at address ack
// - writes stay pending; stop copies them into active registers
// - limit code 0x00 is 100mA, 0x1f is custom
module charger_irq_and_smbus_read (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  input  wire logic                       input_power_present,
  input  wire logic                       custom_default_cfg,
  input  wire charger_irq_pkg::status_t   live_status,
  output logic                            sda_out,
  output logic                            sda_oe,
  output logic                            irq_n,
  output charger_irq_pkg::command_t       active_command
);

  charger_irq_pkg::design_t st_q;
  charger_irq_pkg::design_t st_d;
  charger_irq_pkg::pins_t   cur_w;
  charger_irq_pkg::pins_t   prv_w;
  logic                     rise_w;
  logic                     fall_w;
  logic                     start_w;
  logic                     stop_w;
  logic                     evt_w;
  logic                     clr_w;
  logic                     pwr_rise_w;
  logic [15:0]              diff_w;
  logic [5:0]               hits_w;
  logic [4:0]               dflt_w;

  // write one command byte at the pointer; status and unknown offsets ignore it
  function automatic charger_irq_pkg::command_t write_cmd(
    input charger_irq_pkg::command_t c,
    input logic [7:0]                p,
    input logic [7:0]                v);
    charger_irq_pkg::command_t r;
    r = c;
    case (p)
      charger_irq_pkg::SUB_CTL0: r.ctl0 = v;
      charger_irq_pkg::SUB_CTL1: r.ctl1 = v;
      charger_irq_pkg::SUB_CTL2: r.ctl2 = v;
      charger_irq_pkg::SUB_MASK: r.mask = v;
      charger_irq_pkg::SUB_CTL7: r.ctl7 = v;
      default: r = c;
    endcase
    return r;
  endfunction

  // pick the byte to transmit: pending command data or the status snapshot
  function automatic logic [7:0] read_reg(
    input charger_irq_pkg::command_t c,
    input charger_irq_pkg::status_t  s,
    input logic [7:0]                p);
    logic [7:0] r;
    r = charger_irq_pkg::UNMAPPED_RD;
    case (p)
      charger_irq_pkg::SUB_CTL0:  r = c.ctl0;
      charger_irq_pkg::SUB_CTL1:  r = c.ctl1;
      charger_irq_pkg::SUB_CTL2:  r = c.ctl2;
      charger_irq_pkg::SUB_STAT3: r = s.stat3;
      charger_irq_pkg::SUB_STAT4: r = s.stat4;
      charger_irq_pkg::SUB_STAT5: r = s.stat5;
      charger_irq_pkg::SUB_MASK:  r = c.mask;
      charger_irq_pkg::SUB_CTL7:  r = c.ctl7;
      default:                    r = charger_irq_pkg::UNMAPPED_RD;
    endcase
    return r;
  endfunction

  always_comb begin
    st_d    = st_q;
    clr_w   = 1'b0;
    // three-stage input filter; a bit moves once stages two and three agree
    st_d.s1   = {scl_in, sda_in, input_power_present, custom_default_cfg, live_status};
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.flt  = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.flt);
    st_d.prev = st_q.flt;
    cur_w   = st_q.flt;
    prv_w   = st_q.prev;
    rise_w  = cur_w.scl & ~prv_w.scl;
    fall_w  = ~cur_w.scl & prv_w.scl;
    start_w = cur_w.scl & prv_w.scl & ~cur_w.sda & prv_w.sda;
    stop_w  = cur_w.scl & prv_w.scl & cur_w.sda & ~prv_w.sda;
    // group change detection against the previous sample
    diff_w  = {cur_w.stat.stat3, cur_w.stat.stat4} ^ {prv_w.stat.stat3, prv_w.stat.stat4};
    hits_w  = {|(diff_w & charger_irq_pkg::TRIG_CHARGER), |(diff_w & charger_irq_pkg::TRIG_FAULT),
               |(diff_w & charger_irq_pkg::TRIG_POWER), |(diff_w & charger_irq_pkg::TRIG_OTG),
               |(diff_w & charger_irq_pkg::TRIG_ILIM), |(diff_w & charger_irq_pkg::TRIG_UVCL)};
    evt_w   = |(hits_w & st_q.act.mask[7:2]);
    // input power applied: restore default limit mode in both copies
    pwr_rise_w = cur_w.power & ~prv_w.power;
    dflt_w     = cur_w.custom ? charger_irq_pkg::LIMIT_CUSTOM : charger_irq_pkg::LIMIT_100MA;
    if (pwr_rise_w) begin
      st_d.pend.ctl0[4:0] = dflt_w;
      st_d.pend.ctl1[4:0] = dflt_w;
      st_d.act.ctl0[4:0]  = dflt_w;
      st_d.act.ctl1[4:0]  = dflt_w;
    end
    if (stop_w) begin
      st_d.bus    = charger_irq_pkg::BUS_IDLE;
      st_d.sda_oe = 1'b0;
      st_d.act    = st_d.pend;
    end else if (start_w) begin
      st_d.bus    = charger_irq_pkg::BUS_RX;
      st_d.cnt    = 4'h0;
      st_d.bidx   = 2'h0;
      st_d.sda_oe = 1'b0;
    end else begin
      case (st_q.bus)
        charger_irq_pkg::BUS_RX: begin
          if (rise_w) begin
            st_d.sh  = {st_q.sh[6:0], cur_w.sda};
            st_d.cnt = st_q.cnt + 4'h1;
          end else if (fall_w && st_q.cnt == 4'h8) begin
            if (st_q.bidx == 2'h0 && st_q.sh[7:1] != charger_irq_pkg::SLAVE_ADDR) begin
              st_d.bus = charger_irq_pkg::BUS_IDLE;
            end else begin
              st_d.sda_oe = 1'b1;
              st_d.bus    = charger_irq_pkg::BUS_ACK;
              if (st_q.bidx == 2'h0) begin
                st_d.rw = st_q.sh[0];
                if (st_q.sh[0]) begin
                  // snapshot at address ack, or frozen bytes while a request pends
                  st_d.sh = read_reg(st_q.pend, st_q.irq_pend ? st_q.frozen : cur_w.stat,
                                     st_q.ptr);
                end
              end else if (st_q.bidx == 2'h1) begin
                st_d.ptr = st_q.sh;
              end else begin
                st_d.pend = write_cmd(st_d.pend, st_q.ptr, st_q.sh);
                clr_w     = (st_q.ptr == charger_irq_pkg::SUB_MASK);
              end
            end
          end
        end
        charger_irq_pkg::BUS_ACK: begin
          if (fall_w) begin
            if (st_q.rw && st_q.bidx == 2'h0) begin
              st_d.sda_oe = ~st_q.sh[7];
              st_d.sh     = {st_q.sh[6:0], 1'b0};
              st_d.cnt    = 4'h1;
              st_d.bus    = charger_irq_pkg::BUS_TX;
            end else begin
              st_d.sda_oe = 1'b0;
              st_d.cnt    = 4'h0;
              st_d.bus    = charger_irq_pkg::BUS_RX;
              if (st_q.bidx != 2'h2) begin
                st_d.bidx = st_q.bidx + 2'h1;
              end
            end
          end
        end
        charger_irq_pkg::BUS_TX: begin
          if (fall_w) begin
            if (st_q.cnt == 4'h8) begin
              st_d.sda_oe = 1'b0;
              st_d.bus    = charger_irq_pkg::BUS_FILL;
            end else begin
              st_d.sda_oe = ~st_q.sh[7];
              st_d.sh     = {st_q.sh[6:0], 1'b0};
              st_d.cnt    = st_q.cnt + 4'h1;
            end
          end
        end
        charger_irq_pkg::BUS_IDLE,
        charger_irq_pkg::BUS_FILL: st_d.sda_oe = 1'b0;
        default: st_d.bus = charger_irq_pkg::BUS_IDLE;
      endcase
    end
    // request latch; a new event in the clearing cycle wins
    if (clr_w) begin
      st_d.irq_pend = 1'b0;
    end
    if (evt_w && !st_d.irq_pend) begin
      st_d.irq_pend = 1'b1;
      st_d.frozen   = cur_w.stat;
    end
    st_d.irq_n   = ~st_d.irq_pend;
    st_d.sda_out = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q          <= '0;
      st_q.bus      <= charger_irq_pkg::BUS_IDLE;
      st_q.pend     <= {5{charger_irq_pkg::CMD_RESET}};
      st_q.act      <= {5{charger_irq_pkg::CMD_RESET}};
      st_q.pend.mask <= charger_irq_pkg::MASK_RESET;
      st_q.act.mask <= charger_irq_pkg::MASK_RESET;
      st_q.irq_n    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign sda_out        = st_q.sda_out;
  assign sda_oe         = st_q.sda_oe;
  assign irq_n          = st_q.irq_n;
  assign active_command = st_q.act;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence irq_trigger_s;
    evt_w && !st_q.irq_pend && !clr_w;
  endsequence

  sequence read_addr_ack_s;
    st_q.bus == charger_irq_pkg::BUS_RX && st_q.cnt == 4'h8 && fall_w && st_q.bidx == 2'h0
      && st_q.sh == {charger_irq_pkg::SLAVE_ADDR, 1'b1} && !start_w && !stop_w;
  endsequence

  sequence mask_write_s;
    clr_w && !evt_w;
  endsequence

  sequence wrong_addr_s;
    st_q.bus == charger_irq_pkg::BUS_RX && st_q.cnt == 4'h8 && fall_w && st_q.bidx == 2'h0
      && st_q.sh[7:1] != charger_irq_pkg::SLAVE_ADDR && !start_w && !stop_w;
  endsequence

  sequence tx_active_s;
    st_q.bus == charger_irq_pkg::BUS_TX && !start_w && !stop_w;
  endsequence

  sequence all_masked_s;
    st_q.act.mask[7:2] == 6'h00 && !st_q.irq_pend;
  endsequence

  irq_level_a: assert property (irq_trigger_s |=> !irq_n && st_q.irq_pend)
    else $error("interrupt pin not driven low after enabled event");
  freeze_latch_a: assert property (irq_trigger_s |=> st_q.frozen == $past(cur_w.stat))
    else $error("status not latched at interrupt");
  freeze_hold_a: assert property (st_q.irq_pend && !clr_w |=> st_q.frozen == $past(st_q.frozen))
    else $error("frozen status changed while pending");
  irq_clear_a: assert property (mask_write_s |=> irq_n ##1 irq_n || $past(evt_w))
    else $error("mask write did not release interrupt");
  mask_reset_a: assert property ($fell(reset) |-> st_q.act.mask == charger_irq_pkg::MASK_RESET)
    else $error("mask not cleared by reset");
  ptr_hold_a: assert property ($changed(st_q.ptr) |-> $past(st_q.bidx) == 2'h1 && !$past(st_q.rw))
    else $error("pointer changed outside a write");
  commit_a: assert property (stop_w |=> st_q.act == st_q.pend)
    else $error("stop did not commit pending data");
  power_default_a: assert property (pwr_rise_w |=> st_q.act.ctl0[4:0] == $past(dflt_w)
                                    && st_q.act.ctl1[4:0] == $past(dflt_w))
    else $error("limit fields not defaulted on power");
  read_ack_a: assert property (read_addr_ack_s |=> sda_oe && st_q.bus == charger_irq_pkg::BUS_ACK)
    else $error("read address not acknowledged");
  one_byte_a: assert property (st_q.bus == charger_irq_pkg::BUS_FILL |-> !sda_oe)
    else $error("data driven after the single byte");
  addr_reject_a: assert property (wrong_addr_s
                                  |=> !sda_oe && st_q.bus == charger_irq_pkg::BUS_IDLE)
    else $error("foreign address acknowledged");
  ptr_read_a: assert property (tx_active_s |=> st_q.ptr == $past(st_q.ptr))
    else $error("pointer moved during a read");
  tx_count_a: assert property (tx_active_s |-> st_q.cnt >= 4'h1 && st_q.cnt <= 4'h8)
    else $error("transmit bit count out of range");
  pin_level_a: assert property (irq_n == !st_q.irq_pend)
    else $error("interrupt pin differs from pending request");
  clear_release_a: assert property (mask_write_s |=> !st_q.irq_pend)
    else $error("request still pending after mask write");
  masked_quiet_a: assert property (all_masked_s |=> !st_q.irq_pend)
    else $error("request raised with all groups masked");
  act_hold_a: assert property (!stop_w && !pwr_rise_w
                               |=> st_q.act == $past(st_q.act))
    else $error("active command changed without stop");
  pend_default_a: assert property (pwr_rise_w && !(fall_w && st_q.bus == charger_irq_pkg::BUS_RX)
                                   |=> st_q.pend.ctl0[4:0] == $past(dflt_w)
                                   && st_q.pend.ctl1[4:0] == $past(dflt_w))
    else $error("pending limit fields not defaulted on power");

endmodule

`default_nettype wire

// >>> testbench/i2c_host_model.sv
// Purpose: two-wire bus host driving clock and data toward the block
// Assumes: open-drain data wire with pull-up, clock high 8 clocks and low 16 clocks per bit
// Notes:   the bench calls these tasks; the host always clocks the bus itself
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda_w,
  output var logic  scl,
  output var logic  sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic step();
    repeat (8) @(posedge clk);
    #2;
  endtask
  task automatic start();
    sda = 1'b1;
    step();
    scl = 1'b1;
    step();
    sda = 1'b0;
    step();
    scl = 1'b0;
    step();
  endtask
  task automatic stop();
    sda = 1'b0;
    step();
    scl = 1'b1;
    step();
    sda = 1'b1;
    step();
  endtask
  task automatic bit_out(input logic b);
    sda = b;
    step();
    scl = 1'b1;
    step();
    scl = 1'b0;
    step();
  endtask
  task automatic bit_in(output logic b);
    sda = 1'b1;
    step();
    scl = 1'b1;
    step();
    b = sda_w;
    scl = 1'b0;
    step();
  endtask
  task automatic write_byte(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(nak);
  endtask
  task automatic read_byte(output logic [7:0] d, input logic mnak);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(mnak);
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_charger_irq_and_smbus_read.sv
// Purpose: self-checking bench for the interrupt and two-wire read block
// Assumes: host model on the bus, status and power driven by the bench
// Notes:   random data from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none
module test_charger_irq_and_smbus_read;
  logic                      clk = 1'b0;
  logic                      reset;
  logic                      power;
  logic                      custom;
  charger_irq_pkg::status_t  live;
  charger_irq_pkg::status_t  frz;
  charger_irq_pkg::command_t act;
  logic                      scl;
  logic                      sda_h;
  logic                      sda_out;
  logic                      sda_oe;
  logic                      irq_n;
  logic                      sda_w;
  logic                      a;
  logic [7:0]                d;
  logic [7:0]                m;
  logic [31:0]               v;
  logic [31:0]               seed = 32'h3f927bd9;
  logic [15:0]               trig [6];
  int                        n_fail = 0;
  int                        checked = 0;

  always #25 clk = ~clk;
  assign sda_w = sda_h & (sda_oe ? sda_out : 1'b1);

  charger_irq_and_smbus_read charger_irq_and_smbus_read_inst (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_w), .input_power_present(power),
    .custom_default_cfg(custom), .live_status(live), .sda_out(sda_out), .sda_oe(sda_oe),
    .irq_n(irq_n), .active_command(act));
  i2c_host_model i2c_host_model_inst (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda_h));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [4:0] exp_limit(input logic c);
    return c ? charger_irq_pkg::LIMIT_CUSTOM : charger_irq_pkg::LIMIT_100MA;
  endfunction
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic settle();
    repeat (10) @(posedge clk);
    #2;
  endtask
  task automatic head(input logic [7:0] p);
    i2c_host_model_inst.start();
    i2c_host_model_inst.write_byte(8'h12, a);
    check(a, 1'b0);
    i2c_host_model_inst.write_byte(p, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] dv);
    head(p);
    i2c_host_model_inst.write_byte(dv, a);
    i2c_host_model_inst.stop();
    settle();
  endtask
  task automatic rx(output logic [7:0] dv);
    i2c_host_model_inst.start();
    i2c_host_model_inst.write_byte(8'h13, a);
    check(a, 1'b0);
    i2c_host_model_inst.read_byte(dv, 1'b1);
    i2c_host_model_inst.stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] dv);
    head(p);
    rx(dv);
  endtask

  initial begin
    reset = 1'b1;
    power = 1'b1;
    custom = 1'b0;
    live = '0;
    trig = '{charger_irq_pkg::TRIG_CHARGER, charger_irq_pkg::TRIG_FAULT,
             charger_irq_pkg::TRIG_POWER, charger_irq_pkg::TRIG_OTG,
             charger_irq_pkg::TRIG_ILIM, charger_irq_pkg::TRIG_UVCL};
    repeat (3) @(posedge clk);
    #2;
    reset = 1'b0;
    settle();
    check(irq_n, 1'b1);
    check(act.mask, 8'h00);
    wr(charger_irq_pkg::SUB_CTL0, 8'h0a);
    check(act.ctl0, 8'h0a);
    for (int k = 1; k >= 0; k--) begin
      custom = k[0];
      power = 1'b0;
      settle();
      power = 1'b1;
      settle();
      check(act.ctl0[4:0], exp_limit(custom));
      check(act.ctl1[4:0], exp_limit(custom));
      rd(charger_irq_pkg::SUB_CTL1, d);
      check(d[4:0], exp_limit(custom));
    end
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      m = k[0] ? charger_irq_pkg::SUB_CTL7 : charger_irq_pkg::SUB_CTL2;
      wr(m, v[7:0]);
      check(k[0] ? act.ctl7 : act.ctl2, v[7:0]);
      rx(d);
      check(d, v[7:0]);
      rx(d);
      check(d, v[7:0]);
    end
    for (int g = 0; g < 6; g++) begin
      m = 8'h80 >> g;
      wr(charger_irq_pkg::SUB_MASK, m);
      check(act.mask, m);
      v = rnd();
      live = live ^ {trig[(g + 1) % 6], v[7:0]};
      settle();
      check(irq_n, 1'b1);
      live = live ^ {trig[g], 8'h00};
      settle();
      check(irq_n, 1'b0);
      frz = live;
      live = live ^ {trig[g], v[15:8]};
      settle();
      rd(charger_irq_pkg::SUB_STAT3 + 8'(g % 3), d);
      check(d, frz[23 - 8 * (g % 3) -: 8]);
      wr(charger_irq_pkg::SUB_CTL2, v[23:16]);
      rx(d);
      check(d, v[23:16]);
      check(irq_n, 1'b0);
      wr(charger_irq_pkg::SUB_MASK, m);
      check(irq_n, 1'b1);
      rd(charger_irq_pkg::SUB_STAT3 + 8'((g % 3) != 0), d);
      check(d, live[23 - 8 * ((g % 3) != 0) -: 8]);
    end
    i2c_host_model_inst.start();
    i2c_host_model_inst.write_byte(8'h15, a);
    check(a, 1'b1);
    i2c_host_model_inst.stop();
    i2c_host_model_inst.start();
    i2c_host_model_inst.write_byte(8'h13, a);
    i2c_host_model_inst.read_byte(d, 1'b0);
    i2c_host_model_inst.read_byte(d, 1'b1);
    check(d, 8'hff);
    i2c_host_model_inst.stop();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
